// ===== pio_dual_port.sv
// Top of the dual-port parallel I/O block with priority chain
// Overview of operation
// - Two bidirectional eight-line ports exchange data with outside logic.
// - The five control-code lines steer what the block does.
// - Eight three-state bus lines, released whenever the block is not source.
// - Open-drain bus-drive flag low exactly while the block sources the bus.
// - Falling edge on external interrupt input raises an interrupt request.
// - Request output low only with chain input low and request pending.
// - Chain output high unless chain input low and nothing pending.
// - Port write latches the accumulator byte from the bus into addressed port.
// - Port read puts the addressed port's pin contents on the bus.
// - Pins inverted: stored one drives low, high pin reads zero.
// - Each line has its own latch holding the last written value.
// - Each pin is wired-AND of latch drive and outside signal.
// - Reset leaves port latches untouched, so they keep the last value written.
// - Ports use the standard pull-up output form only.
// - Low address bits 00 port A, 01 port B, 10 control, 11 timer.
// - Only the two ports answer reads; control and timer stay off the bus.
// - Port latches change at the end of the transfer cycle.
module pio_dual_port
	import pio_pkg::*;
#(
	parameter logic [SEL_W-1:0]  SELECT   = SELECT_DEF,   // Upper six address bits
	parameter logic [CODE_W-1:0] CODE_OUT = CODE_OUT_DEF, // Output transfer cycle
	parameter logic [CODE_W-1:0] CODE_IN  = CODE_IN_DEF,  // Input transfer cycle
	parameter logic [CODE_W-1:0] CODE_ACK = CODE_ACK_DEF  // Interrupt acknowledge cycle
)(
	input  wire logic              clk_in,                // System clock, 250 MHz
	input  wire logic              rst_b_in,              // Async reset, active low
	input  wire logic              phase_clk_in,          // Processor phase clock pin
	input  wire logic              write_clk_in,          // Processor write clock pin
	input  wire logic [CODE_W-1:0] cpu_control_code_in,   // Control code lines
	input  wire logic [DATA_W-1:0] data_bus_in,           // Resolved byte bus level
	output logic      [DATA_W-1:0] data_bus_out,          // Byte bus drive value
	output logic                   data_bus_oe_out,       // High while driving the bus
	output logic                   bus_drive_flag_out,    // Flag drive level, always low
	output logic                   bus_drive_flag_oe_out, // High while pulling flag low
	input  wire logic              external_interrupt_in, // External request pin
	input  wire logic              priority_chain_in,     // Chain input, low = may ask
	output logic                   priority_chain_out,    // Chain output to next device
	output logic                   int_req_b_out,         // Interrupt request, active low
	input  wire logic [DATA_W-1:0] port_a_in,             // Port A pin level
	output logic      [DATA_W-1:0] port_a_out,            // Port A drive level
	output logic      [DATA_W-1:0] port_a_oe_out,         // Port A pull-low enables
	input  wire logic [DATA_W-1:0] port_b_in,             // Port B pin level
	output logic      [DATA_W-1:0] port_b_out,            // Port B drive level
	output logic      [DATA_W-1:0] port_b_oe_out          // Port B pull-low enables
);
	logic [SYNC_W-1:0] meta_q;
	logic [SYNC_W-1:0] sync_q;
	logic              write_last_q;
	logic              phase_last_q;
	logic              ext_last_q;
	logic              cyc_end;
	logic              phase_rise;
	logic              ext_fall;
	logic [DATA_W-1:0] bus_sync;
	logic [CODE_W-1:0] code_sync;
	logic              pri_sync;

	logic [CODE_W-1:0] code_q;
	logic              match_q;
	logic [SUB_W-1:0]  sub_q;
	logic [1:0]        int_ctrl_q;
	pio_int_e          int_q;
	pio_int_e          int_d;
	logic              pending;

	logic              out_cycle;
	logic              rd_active_d;
	logic [DATA_W-1:0] rd_data_d;
	logic [DATA_W-1:0] bus_data_q;
	logic              bus_oe_q;
	logic              flag_oe_q;
	logic              int_req_b_q;
	logic              chain_out_q;

	pio_port_if port_a_if ();
	pio_port_if port_b_if ();

	// Every pin input, the two processor clocks among them, is foreign to clk_in
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_q <= SYNC_RESET;
			sync_q <= SYNC_RESET;
		end else begin
			meta_q <= {write_clk_in, phase_clk_in, external_interrupt_in,
				priority_chain_in, cpu_control_code_in, data_bus_in};
			sync_q <= meta_q;
		end
	end

	assign bus_sync  = sync_q[SY_BUS_LO +: DATA_W];
	assign code_sync = sync_q[SY_CODE_LO +: CODE_W];
	assign pri_sync  = sync_q[SY_PRI];

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			write_last_q <= 1'b1;
			phase_last_q <= 1'b1;
			ext_last_q   <= 1'b1;
		end else begin
			write_last_q <= sync_q[SY_WRITE];
			phase_last_q <= sync_q[SY_PHASE];
			ext_last_q   <= sync_q[SY_EXT];
		end
	end

	// Write clock rise closes an instruction cycle
	assign cyc_end    = sync_q[SY_WRITE] & ~write_last_q;
	assign phase_rise = sync_q[SY_PHASE] & ~phase_last_q;
	assign ext_fall   = ~sync_q[SY_EXT] & ext_last_q;

	// Control code is taken on the phase clock so it is stable for the cycle
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			code_q <= CODE_RESET;
		end else if (phase_rise) begin
			code_q <= code_sync;
		end
	end

	// Address watch runs every cycle; the result is held through the next one
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			match_q <= 1'b0;
			sub_q   <= SUB_PORT_A;
		end else if (cyc_end) begin
			match_q <= (bus_sync[DATA_W-1:SUB_W] == SELECT);
			sub_q   <= bus_sync[SUB_W-1:0];
		end
	end

	assign out_cycle = cyc_end & (code_q == CODE_OUT) & match_q;

	// Latches load as the transfer cycle closes
	assign port_a_if.wr_stb  = out_cycle & (sub_q == SUB_PORT_A);
	assign port_b_if.wr_stb  = out_cycle & (sub_q == SUB_PORT_B);
	assign port_a_if.wr_data = bus_sync;
	assign port_b_if.wr_data = bus_sync;

	// Control address loads the low two bus bits; a timer address write changes nothing
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			int_ctrl_q <= INT_CTRL_RESET;
		end else if (out_cycle && (sub_q == SUB_INT_CTRL)) begin
			int_ctrl_q <= bus_sync[1:0];
		end
	end

	// A new edge in the acknowledge cycle wins so no request is dropped
	always_comb begin
		int_d = int_q;
		case (int_q)
			PIO_INT_IDLE: begin
				if (ext_fall && (int_ctrl_q == INT_CTRL_EXT_EN)) begin
					int_d = PIO_INT_PEND;
				end
			end
			PIO_INT_PEND: begin
				if (ext_fall && (int_ctrl_q == INT_CTRL_EXT_EN)) begin
					int_d = PIO_INT_PEND;
				end else if (cyc_end && (code_q == CODE_ACK) && !pri_sync) begin
					int_d = PIO_INT_IDLE;
				end
			end
			default: begin
				int_d = PIO_INT_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			int_q <= PIO_INT_IDLE;
		end else begin
			int_q <= int_d;
		end
	end

	assign pending = (int_q == PIO_INT_PEND);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			int_req_b_q <= 1'b1;
			chain_out_q <= 1'b1;
		end else begin
			int_req_b_q <= ~(pending & ~pri_sync);
			chain_out_q <= pri_sync | pending;
		end
	end

	// Control and timer addresses never answer a read
	assign rd_active_d = (code_q == CODE_IN) & match_q &
		((sub_q == SUB_PORT_A) | (sub_q == SUB_PORT_B));
	assign rd_data_d   = (sub_q == SUB_PORT_B) ? port_b_if.rd_data : port_a_if.rd_data;

	// Flag and bus enable share one condition so they can never disagree
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bus_oe_q   <= 1'b0;
			flag_oe_q  <= 1'b0;
			bus_data_q <= 8'h00;
		end else begin
			bus_oe_q   <= rd_active_d;
			flag_oe_q  <= rd_active_d;
			bus_data_q <= rd_active_d ? rd_data_d : 8'h00;
		end
	end

	assign data_bus_out          = bus_data_q;
	assign data_bus_oe_out       = bus_oe_q;
	assign bus_drive_flag_out    = 1'b0;
	assign bus_drive_flag_oe_out = flag_oe_q;
	assign int_req_b_out         = int_req_b_q;
	assign priority_chain_out    = chain_out_q;

	pio_port u_port_a (
		.clk_in     (clk_in),
		.rst_b_in   (rst_b_in),
		.bus_if     (port_a_if),
		.pin_in     (port_a_in),
		.pin_out    (port_a_out),
		.pin_oe_out (port_a_oe_out)
	);

	pio_port u_port_b (
		.clk_in     (clk_in),
		.rst_b_in   (rst_b_in),
		.bus_if     (port_b_if),
		.pin_in     (port_b_in),
		.pin_out    (port_b_out),
		.pin_oe_out (port_b_oe_out)
	);

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_out_a;
		cyc_end && (code_q == CODE_OUT) && match_q && (sub_q == SUB_PORT_A);
	endsequence

	sequence s_out_b;
		cyc_end && (code_q == CODE_OUT) && match_q && (sub_q == SUB_PORT_B);
	endsequence

	sequence s_read_ctrl;
		(code_q == CODE_IN) && match_q && sub_q[1];
	endsequence

	sequence s_ext_armed;
		ext_fall && (int_ctrl_q == INT_CTRL_EXT_EN);
	endsequence

	sequence s_ext_masked;
		ext_fall && (int_ctrl_q != INT_CTRL_EXT_EN) && !pending;
	endsequence

	sequence s_ack_clean;
		cyc_end && (code_q == CODE_ACK) && !pri_sync &&
			!(ext_fall && (int_ctrl_q == INT_CTRL_EXT_EN));
	endsequence

	sequence s_ctrl_write;
		cyc_end && (code_q == CODE_OUT) && match_q && (sub_q == SUB_INT_CTRL);
	endsequence

	sequence s_timer_write;
		out_cycle && (sub_q == SUB_TIMER);
	endsequence

	a_bus_release_idle: assert property (!rd_active_d |=> !data_bus_oe_out)
		else $error("bus driven outside a read cycle");
	a_flag_follows_bus: assert property (bus_drive_flag_oe_out == data_bus_oe_out)
		else $error("bus-drive flag disagrees with bus drive");
	a_read_data_val: assert property (rd_active_d |=> data_bus_oe_out && data_bus_out == $past(rd_data_d))
		else $error("read byte wrong or not driven");
	a_ctrl_no_read: assert property (s_read_ctrl |=> !data_bus_oe_out)
		else $error("control or timer address drove the bus");
	a_port_a_load: assert property (s_out_a |=> port_a_oe_out == $past(bus_sync))
		else $error("port A did not take the bus byte");
	a_port_b_load: assert property (s_out_b |=> port_b_oe_out == $past(bus_sync))
		else $error("port B did not take the bus byte");
	a_ext_sets_pend: assert property (s_ext_armed |=> pending ##1
		($past(pri_sync) || !int_req_b_out))
		else $error("external edge lost");
	a_int_req_cause: assert property (!int_req_b_out |-> $past(pending) && !$past(pri_sync))
		else $error("request asserted without cause");
	a_chain_out_low: assert property (!priority_chain_out |-> !$past(pri_sync) && !$past(pending))
		else $error("chain output low while blocked or pending");
	a_code_stable: assert property (!phase_rise |=> $stable(code_q))
		else $error("control code moved off the phase edge");

	// Interrupt control, chain pass-through and idle bus value
	a_ack_clears_pend: assert property (s_ack_clean |=> !pending)
		else $error("acknowledge did not clear the request");
	a_edge_off_ignored: assert property (s_ext_masked |=> !pending)
		else $error("edge taken while external interrupt disabled");
	a_ctrl_write_load: assert property (s_ctrl_write |=> int_ctrl_q == $past(bus_sync[1:0]))
		else $error("interrupt control did not take the bus bits");
	a_timer_write_off: assert property (s_timer_write |=> $stable(int_ctrl_q))
		else $error("timer address write changed interrupt control");
	a_req_when_due: assert property (pending && !pri_sync |=> !int_req_b_out)
		else $error("request not raised while due");
	a_chain_pass_high: assert property (pri_sync |=> priority_chain_out)
		else $error("chain output low while chain input high");
	a_bus_zero_idle: assert property (!data_bus_oe_out |-> data_bus_out == 8'h00)
		else $error("bus value not cleared while released");
endmodule

// ===== pio_pkg.sv
// Shared constants for the dual-port parallel I/O block
package pio_pkg;
	localparam int         DATA_W        = 8;
	localparam int         CODE_W        = 5;
	localparam int         SEL_W         = 6;
	localparam int         SUB_W         = 2;
	localparam int         SYNC_W        = 17;

	// Low address bits inside the device's block of four
	localparam logic [1:0] SUB_PORT_A    = 2'h0;
	localparam logic [1:0] SUB_PORT_B    = 2'h1;
	localparam logic [1:0] SUB_INT_CTRL  = 2'h2;
	localparam logic [1:0] SUB_TIMER     = 2'h3;

	// Interrupt control port coding, only the low two bits count
	localparam logic [1:0] INT_CTRL_EXT_EN = 2'h1;
	localparam logic [1:0] INT_CTRL_RESET  = 2'h0;

	// Defaults for the per-version select code and control codes
	localparam logic [5:0] SELECT_DEF    = 6'h01;
	localparam logic [4:0] CODE_OUT_DEF  = 5'h1A;
	localparam logic [4:0] CODE_IN_DEF   = 5'h1B;
	localparam logic [4:0] CODE_ACK_DEF  = 5'h10;
	localparam logic [4:0] CODE_RESET    = 5'h00;

	// Positions inside the synchroniser vector
	localparam int         SY_BUS_LO     = 0;
	localparam int         SY_CODE_LO    = 8;
	localparam int         SY_PRI        = 13;
	localparam int         SY_EXT        = 14;
	localparam int         SY_PHASE      = 15;
	localparam int         SY_WRITE      = 16;
	localparam logic [16:0] SYNC_RESET   = 17'h1E000;
	localparam logic [7:0] PIN_RESET     = 8'hFF;

	typedef enum logic [1:0] {
		PIO_INT_IDLE = 2'b01,
		PIO_INT_PEND = 2'b10
	} pio_int_e;
endpackage

// ===== pio_port_if.sv
// Carrier between the core and one port slice
interface pio_port_if;
	logic        wr_stb;
	logic [7:0]  wr_data;
	logic [7:0]  rd_data;

	modport core (output wr_stb, output wr_data, input rd_data);
	modport port (input wr_stb, input wr_data, output rd_data);
endinterface

// ===== pio_port.sv
// One eight-line inverted wire-AND port slice
module pio_port
	import pio_pkg::*;
(
	input  wire logic              clk_in,     // System clock
	input  wire logic              rst_b_in,   // Async reset, active low
	pio_port_if.port               bus_if,     // Write strobe and read value
	input  wire logic [DATA_W-1:0] pin_in,     // Resolved pin level
	output logic      [DATA_W-1:0] pin_out,    // Driven level, always low
	output logic      [DATA_W-1:0] pin_oe_out  // High while pulling the pin low
);
	logic [DATA_W-1:0] latch_q;
	logic [DATA_W-1:0] pin_meta_q;
	logic [DATA_W-1:0] pin_sync_q;
	logic [DATA_W-1:0] rd_q;
	logic              loaded_q;

	// Deliberately no reset: contents after reset are whatever was last held
	always_ff @(posedge clk_in) begin
		if (bus_if.wr_stb) begin
			latch_q <= bus_if.wr_data;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_meta_q <= PIN_RESET;
			pin_sync_q <= PIN_RESET;
		end else begin
			pin_meta_q <= pin_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	// A held one masks the input; a high pin reads as zero
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_q <= 8'h00;
		end else begin
			rd_q <= latch_q | ~pin_sync_q;
		end
	end

	// Stored one pulls low, stored zero releases to the pull-up
	assign pin_oe_out     = latch_q;
	assign pin_out        = 8'h00;
	assign bus_if.rd_data = rd_q;

	// Helper for the read check only: the latch is unknown until its first write
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			loaded_q <= 1'b0;
		end else if (bus_if.wr_stb) begin
			loaded_q <= 1'b1;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	a_latch_hold_val: assert property (!bus_if.wr_stb |=> $stable(pin_oe_out))
		else $error("port latch changed without a write");
	a_read_merge_pin: assert property ($past(loaded_q) |->
		rd_q == ($past(latch_q) | ~$past(pin_sync_q)))
		else $error("port read is not latch or inverted pin");
endmodule

// ===== pio_cpu_model.sv
// Processor-side model: clock pins, control codes and the shared byte bus
module pio_cpu_model
	import pio_pkg::*;
(
	input  wire logic              clk_in,        // System clock
	input  wire logic [DATA_W-1:0] dev_data_in,   // Block bus drive value
	input  wire logic              dev_oe_in,     // Block drives the bus
	output logic                   phase_clk_out, // Phase clock pin
	output logic                   write_clk_out, // Write clock pin
	output logic      [CODE_W-1:0] code_out,      // Control code lines
	output logic      [DATA_W-1:0] bus_out,       // Resolved bus level
	output logic      [DATA_W-1:0] read_data_out  // Byte taken at write rise
);
	logic              cpu_oe = 1'b0;
	logic [DATA_W-1:0] cpu_data = 8'h00;
	logic [DATA_W-1:0] last_q = 8'h00;
	int                drive_cnt = 0;
	event              got;

	// A released bus shows the inverse of its last value, so stale data never passes
	assign bus_out = dev_oe_in ? dev_data_in : (cpu_oe ? cpu_data : ~last_q);

	initial begin
		phase_clk_out = 1'b0;
		write_clk_out = 1'b0;
		code_out      = 5'h1F;
		read_data_out = 8'h00;
	end

	always @(posedge clk_in) begin
		if (dev_oe_in || cpu_oe)
			last_q <= bus_out;
		if (dev_oe_in)
			drive_cnt <= drive_cnt + 1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	// One instruction cycle; code and bus stay put until the cycle is over
	task automatic cycle(input logic [CODE_W-1:0] code, input logic drive,
		input logic [DATA_W-1:0] data);
		tick(1);
		code_out = code;
		cpu_oe   = drive;
		cpu_data = data;
		tick(2);
		phase_clk_out = 1'b1;
		tick(3);
		phase_clk_out = 1'b0;
		tick(3);
		write_clk_out = 1'b1;
		if (dev_oe_in) begin
			read_data_out = bus_out;
			->got;
		end
		tick(4);
		write_clk_out = 1'b0;
		tick(4);
		cpu_oe = 1'b0;
	endtask
endmodule

// ===== pio_dual_port_bench.sv
// Self-checking bench for the dual-port I/O block
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
	$display("wrong value %s expected %h seen %h", nm, (e), (g)); end end

module pio_dual_port_bench
	import pio_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [4:0] IDLE_CODE = 5'h1F;
	logic       clk_in = 1'b0;
	logic       rst_b_in = 1'b0;
	logic       ext_irq = 1'b1;
	logic       chain_in = 1'b1;
	logic [7:0] ext_a = 8'hFF;
	logic [7:0] ext_b = 8'hFF;
	logic [7:0] da, db, bus, bus_dout, rd_byte, a_oe, b_oe, pa_lvl, pb_lvl;
	logic       phase, write, bus_oe, flag_oe, flag_lvl, chain_out, int_b;
	logic [4:0] code;
	int         fail_count = 0;
	int         comparisons = 0;
	int         seed = 32'h1ce941bf;
	int         n;
	logic [7:0] exp_q[$];

	always #2 clk_in = ~clk_in;

	pio_cpu_model cpu (.clk_in(clk_in), .dev_data_in(bus_dout), .dev_oe_in(bus_oe),
		.phase_clk_out(phase), .write_clk_out(write), .code_out(code), .bus_out(bus),
		.read_data_out(rd_byte));

	pio_dual_port dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .phase_clk_in(phase),
		.write_clk_in(write), .cpu_control_code_in(code), .data_bus_in(bus),
		.data_bus_out(bus_dout), .data_bus_oe_out(bus_oe), .bus_drive_flag_out(flag_lvl),
		.bus_drive_flag_oe_out(flag_oe), .external_interrupt_in(ext_irq),
		.priority_chain_in(chain_in), .priority_chain_out(chain_out), .int_req_b_out(int_b),
		.port_a_in(ext_a & ~(a_oe & ~pa_lvl)), .port_a_out(pa_lvl), .port_a_oe_out(a_oe),
		.port_b_in(ext_b & ~(b_oe & ~pb_lvl)), .port_b_out(pb_lvl), .port_b_oe_out(b_oe));

	task automatic final_report();
		if (exp_q.size() != 0)
			fail_count++;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic xfer(input logic [1:0] sub, input logic [4:0] c, input logic drive,
		input logic [7:0] d);
		cpu.cycle(IDLE_CODE, 1'b1, {SELECT_DEF, sub});
		cpu.cycle(c, drive, d);
	endtask

	task automatic wr(input logic [1:0] sub, input logic [7:0] d);
		xfer(sub, CODE_OUT_DEF, 1'b1, d);
	endtask

	task automatic rd(input logic [1:0] sub, input logic [7:0] e);
		exp_q.push_back(e);
		xfer(sub, CODE_IN_DEF, 1'b0, 8'h00);
	endtask

	task automatic wait_int(input logic lvl);
		int i;
		for (i = 0; i < 20 && int_b !== lvl; i++)
			tick(1);
		if (i == 20) begin
			fail_count++;
			final_report();
		end
	endtask

	// Read results are compared in arrival order against the noted bytes
	initial begin
		logic [7:0] e;
		forever begin
			@(cpu.got);
			e = (exp_q.size() != 0) ? exp_q.pop_front() : ~rd_byte;
			`CHK("read byte", e, rd_byte)
			`CHK("flag during read", 1'b1, flag_oe)
		end
	end

	always @(negedge clk_in) begin
		if (rst_b_in === 1'b1) begin
			`CHK("bus drive flag", bus_oe, flag_oe)
			`CHK("drive levels", 17'h00000, {flag_lvl, pa_lvl, pb_lvl})
		end
	end

	initial begin
		#200000;
		fail_count++;
		final_report();
	end

	initial begin
		tick(3);
		`CHK("bus oe in reset", 1'b0, bus_oe)
		`CHK("request in reset", 1'b1, int_b)
		`CHK("chain in reset", 1'b1, chain_out)
		rst_b_in = 1'b1;
		tick(2);
		for (int k = 0; k < 4; k++) begin
			da = 8'($random(seed));
			db = 8'($random(seed));
			wr(SUB_PORT_A, da);
			wr(SUB_PORT_B, db);
			`CHK("latch a", da, a_oe)
			`CHK("latch b", db, b_oe)
		end
		for (int k = 0; k < 4; k++) begin
			ext_a = 8'($random(seed));
			ext_b = 8'($random(seed));
			rd(SUB_PORT_A, da | ~ext_a);
			rd(SUB_PORT_B, db | ~ext_b);
		end
		// Zeros first, so an old one cannot mask the incoming pin level
		wr(SUB_PORT_A, 8'h00);
		ext_a = 8'($random(seed));
		rd(SUB_PORT_A, ~ext_a);
		cpu.cycle(IDLE_CODE, 1'b1, 8'h00);
		n = cpu.drive_cnt;
		xfer(SUB_INT_CTRL, CODE_IN_DEF, 1'b0, 8'h00);
		xfer(SUB_TIMER, CODE_IN_DEF, 1'b0, 8'h00);
		cpu.cycle(IDLE_CODE, 1'b1, {6'h02, SUB_PORT_A});
		cpu.cycle(CODE_IN_DEF, 1'b0, 8'h00);
		`CHK("refused reads", n, cpu.drive_cnt)
		cpu.cycle(IDLE_CODE, 1'b1, {6'h02, SUB_PORT_A});
		cpu.cycle(CODE_OUT_DEF, 1'b1, 8'h5A);
		xfer(SUB_PORT_A, IDLE_CODE, 1'b1, 8'hA5);
		`CHK("foreign write", 8'h00, a_oe)
		wr(SUB_PORT_A, 8'hC3);
		rst_b_in = 1'b0;
		tick(3);
		rst_b_in = 1'b1;
		tick(2);
		`CHK("latch after reset", 8'hC3, a_oe)
		wr(SUB_INT_CTRL, {6'h00, INT_CTRL_EXT_EN});
		chain_in = 1'b0;
		tick(8);
		`CHK("chain idle", 1'b0, chain_out)
		`CHK("request idle", 1'b1, int_b)
		ext_irq = 1'b0;
		wait_int(1'b0);
		tick(2);
		`CHK("chain pending", 1'b1, chain_out)
		ext_irq = 1'b1;
		chain_in = 1'b1;
		tick(8);
		`CHK("request blocked", 1'b1, int_b)
		chain_in = 1'b0;
		wait_int(1'b0);
		cpu.cycle(CODE_ACK_DEF, 1'b0, 8'h00);
		tick(4);
		`CHK("request cleared", 1'b1, int_b)
		`CHK("chain cleared", 1'b0, chain_out)
		wr(SUB_INT_CTRL, {6'h00, INT_CTRL_RESET});
		ext_irq = 1'b0;
		tick(10);
		ext_irq = 1'b1;
		wr(SUB_INT_CTRL, {6'h00, INT_CTRL_EXT_EN});
		tick(10);
		`CHK("disabled edge", 1'b1, int_b)
		final_report();
	end
endmodule
